// ### tos_defs.svh
`ifndef TOS_DEFS_SVH
`define TOS_DEFS_SVH

`define TOS_CLK_HZ 25000000
`define TOS_CLK_MHZ 25
`define TOS_ACC_W 26
`define TOS_RATE_W 24
`define TOS_RATE_MIN 24'h000001
`define TOS_RATE_MAX 24'h989680
`define TOS_PPS_WIDTH_US 1000
`define TOS_PPS_WIDTH_CYC (`TOS_PPS_WIDTH_US * `TOS_CLK_MHZ)
`define TOS_ONTIME_MAX_US 100
`define TOS_BAUD_DIV_W 13
`define TOS_DIV_57600 (`TOS_CLK_HZ / 57600)
`define TOS_DIV_19200 (`TOS_CLK_HZ / 19200)
`define TOS_DIV_9600 (`TOS_CLK_HZ / 9600)
`define TOS_DIV_4800 (`TOS_CLK_HZ / 4800)

`define TOS_ADDR_W 12
`define TOS_ADDR_CTRL 12'h000
`define TOS_ADDR_PROG_RATE 12'h004
`define TOS_ADDR_RATE_SEL_A_RATE 12'h008
`define TOS_ADDR_PPS_WIDTH 12'h00C
`define TOS_ADDR_STATUS 12'h010

`define TOS_CTRL_SEL_LSB 0
`define TOS_CTRL_FMT_LSB 8
`define TOS_CTRL_BAUD_LSB 12
`define TOS_CTRL_PAR_LSB 16

`define TOS_RST_PROG_RATE 24'h000001
`define TOS_RST_RATE_SEL_A_RATE 24'h000001
`define TOS_RATE_SEL_A_FITTED 1'b1
`define TOS_FIXED_IS_CODE 1'b0
`define TOS_FIXED_RATE 24'h989680

`define TOS_CH_SOH 8'h01
`define TOS_CH_LF 8'h0A
`define TOS_CH_CR 8'h0D
`define TOS_CH_SP 8'h20
`define TOS_CH_DOLLAR 8'h24
`define TOS_CH_STAR 8'h2A
`define TOS_CH_PLUS 8'h2B
`define TOS_CH_COMMA 8'h2C
`define TOS_CH_MINUS 8'h2D
`define TOS_CH_DOT 8'h2E
`define TOS_CH_ZERO 8'h30
`define TOS_CH_COLON 8'h3A
`define TOS_CH_QM 8'h3F
`define TOS_CH_A 8'h41
`define TOS_CH_D 8'h44
`define TOS_CH_G 8'h47
`define TOS_CH_L 8'h4C
`define TOS_CH_P 8'h50
`define TOS_CH_U 8'h55
`define TOS_CH_Z 8'h5A

`endif

// ### tos_pkg.sv
package tos_pkg;
	typedef enum logic [2:0] {
		SEL_RATE = 3'b000,
		SEL_TIMECODE = 3'b001,
		SEL_PER_MINUTE = 3'b010,
		SEL_EVEN_SECOND = 3'b011,
		SEL_RISING = 3'b100,
		SEL_FALLING = 3'b101,
		SEL_RATE_SEL_A = 3'b110
	} tos_sel_type;
	typedef enum logic [2:0] {
		FMT_DOY_UTC = 3'b000,
		FMT_DOY_MODE = 3'b001,
		FMT_YEAR = 3'b010,
		FMT_YEAR_LEAP = 3'b011,
		FMT_NENA = 3'b100,
		FMT_NMEA = 3'b101
	} tos_fmt_type;
	typedef enum logic [1:0] {
		BAUD_57600 = 2'b00,
		BAUD_19200 = 2'b01,
		BAUD_9600 = 2'b10,
		BAUD_4800 = 2'b11
	} tos_baud_type;
	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ODD = 2'b01,
		PAR_EVEN = 2'b10
	} tos_par_type;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_LOAD = 3'b001,
		TX_START = 3'b010,
		TX_DATA = 3'b011,
		TX_PARITY = 3'b100,
		TX_STOP = 3'b101
	} tos_tx_state_type;
	typedef struct packed {
		logic [15:0] year;
		logic [11:0] doy;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
		logic offset_neg;
		logic [7:0] offset;
		logic [1:0] mode;
		logic [3:0] quality;
		logic locked;
		logic [7:0] leap_now;
		logic [7:0] leap_next;
	} tos_time_type;
endpackage

// ### tos_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_defs.svh"
module tos_rate_gen (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	tos_rate_if.gen rg
);
	logic [`TOS_ACC_W-1:0] acc_q;
	logic [`TOS_ACC_W-1:0] sum;
	localparam logic [`TOS_ACC_W-1:0] FULL = `TOS_ACC_W'(`TOS_CLK_HZ);
	localparam logic [`TOS_ACC_W-1:0] HALF = `TOS_ACC_W'(`TOS_CLK_HZ / 2);

	assign sum = acc_q + {2'h0, rg.rate};

	// phase accumulator: rates that do not divide the clock get one cycle of jitter
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_q <= '0;
			rg.wave <= 1'b0;
		end else if (clk_en_i) begin
			if (rg.sync) begin
				acc_q <= '0;
				rg.wave <= 1'b1;
			end else begin
				acc_q <= (sum >= FULL) ? sum - FULL : sum;
				rg.wave <= (acc_q < HALF);
			end
		end
	end
endmodule
`default_nettype wire

// ### tos_rate_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_defs.svh"
interface tos_rate_if;
	logic [`TOS_RATE_W-1:0] rate;
	logic sync;
	logic wave;
	modport gen(input rate, input sync, output wave);
	modport ctl(output rate, output sync, input wave);
endinterface
`default_nettype wire

// ### tos_timing_out.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tos_defs.svh"
module tos_timing_out #(
	parameter int PPS_WIDTH_DEF = `TOS_PPS_WIDTH_CYC,
	parameter int BAUD_DIV_4800 = `TOS_DIV_4800
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`TOS_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic epoch_i,
	input wire tos_pkg::tos_time_type time_i,
	input wire logic timecode_i,
	input wire logic lock_lost_i,
	input wire logic hw_fault_i,
	output logic prog_out_o,
	output logic fixed_out_o,
	output logic pps_p_o,
	output logic pps_n_o,
	output logic alarm_o,
	output logic alarm_oe_o,
	output logic ser_tx_o
);
	import tos_pkg::*;

	tos_sel_type sel_q;
	tos_fmt_type fmt_q;
	tos_baud_type baud_q;
	tos_par_type par_q;
	logic [`TOS_RATE_W-1:0] prog_rate_q;
	logic [`TOS_RATE_W-1:0] rate_sel_a_rate_q;
	logic [`TOS_RATE_W-1:0] pps_width_q;
	logic [`TOS_RATE_W-1:0] pps_cnt_q;
	logic pps_on_q;
	logic minute_q;
	logic even_q;
	logic [31:0] rd_d;
	logic rd_ok;
	logic wr_go;
	logic tx_busy;
	tos_time_type snap_q;
	tos_tx_state_type st_q;
	logic [`TOS_BAUD_DIV_W-1:0] baud_cnt_q;
	logic [`TOS_BAUD_DIV_W-1:0] div;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic par_acc_q;
	logic [5:0] idx_q;
	logic [7:0] csum_q;
	logic [7:0] ch;
	logic [5:0] msg_len;

	tos_rate_if prog_if();
	tos_rate_if rate_sel_a_if();
	tos_rate_if fixed_if();

	assign prog_if.rate = prog_rate_q;
	assign prog_if.sync = epoch_i;
	assign rate_sel_a_if.rate = rate_sel_a_rate_q;
	assign rate_sel_a_if.sync = 1'b0;
	assign fixed_if.rate = `TOS_FIXED_RATE;
	assign fixed_if.sync = epoch_i;

	tos_rate_gen u_prog (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .rg(prog_if));
	tos_rate_gen u_rate_sel_a (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .rg(rate_sel_a_if));
	tos_rate_gen u_fixed (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .rg(fixed_if));

	// one wait state: pready rises at the edge that ends the first access cycle, the transfer ends on the next edge
	assign wr_go = psel_i & penable_i & pready_o & pwrite_i;
	assign tx_busy = (st_q != TX_IDLE);

	always_comb begin
		rd_d = 32'h0000_0000;
		rd_ok = 1'b1;
		case (paddr_i)
			`TOS_ADDR_CTRL: begin
				rd_d[`TOS_CTRL_SEL_LSB +: 3] = sel_q;
				rd_d[`TOS_CTRL_FMT_LSB +: 3] = fmt_q;
				rd_d[`TOS_CTRL_BAUD_LSB +: 2] = baud_q;
				rd_d[`TOS_CTRL_PAR_LSB +: 2] = par_q;
			end
			`TOS_ADDR_PROG_RATE: rd_d[`TOS_RATE_W-1:0] = prog_rate_q;
			`TOS_ADDR_RATE_SEL_A_RATE: rd_d[`TOS_RATE_W-1:0] = rate_sel_a_rate_q;
			`TOS_ADDR_PPS_WIDTH: rd_d[`TOS_RATE_W-1:0] = pps_width_q;
			`TOS_ADDR_STATUS: rd_d[3:0] = {prog_out_o, alarm_oe_o, tx_busy, `TOS_RATE_SEL_A_FITTED};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (clk_en_i) begin
			pready_o <= psel_i & penable_i & ~pready_o;
			if (psel_i & penable_i & ~pready_o) begin
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
				pslverr_o <= ~rd_ok;
			end
		end
	end

	// illegal codes and out-of-range rates are dropped, the old setting stays
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_q <= SEL_RISING;
			fmt_q <= FMT_DOY_UTC;
			baud_q <= BAUD_9600;
			par_q <= PAR_NONE;
			prog_rate_q <= `TOS_RST_PROG_RATE;
			rate_sel_a_rate_q <= `TOS_RST_RATE_SEL_A_RATE;
			pps_width_q <= `TOS_RATE_W'(PPS_WIDTH_DEF);
		end else if (clk_en_i && wr_go) begin
			case (paddr_i)
				`TOS_ADDR_CTRL: begin
					if (pwdata_i[`TOS_CTRL_SEL_LSB +: 3] <= SEL_FALLING ||
						(pwdata_i[`TOS_CTRL_SEL_LSB +: 3] == SEL_RATE_SEL_A && `TOS_RATE_SEL_A_FITTED)) begin
						sel_q <= tos_sel_type'(pwdata_i[`TOS_CTRL_SEL_LSB +: 3]);
					end
					if (pwdata_i[`TOS_CTRL_FMT_LSB +: 3] <= FMT_NMEA) begin
						fmt_q <= tos_fmt_type'(pwdata_i[`TOS_CTRL_FMT_LSB +: 3]);
					end
					baud_q <= tos_baud_type'(pwdata_i[`TOS_CTRL_BAUD_LSB +: 2]);
					if (pwdata_i[`TOS_CTRL_PAR_LSB +: 2] != 2'h3) begin
						par_q <= tos_par_type'(pwdata_i[`TOS_CTRL_PAR_LSB +: 2]);
					end
				end
				`TOS_ADDR_PROG_RATE: begin
					if (pwdata_i[31:0] >= 32'(`TOS_RATE_MIN) && pwdata_i[31:0] <= 32'(`TOS_RATE_MAX)) begin
						prog_rate_q <= pwdata_i[`TOS_RATE_W-1:0];
					end
				end
				`TOS_ADDR_RATE_SEL_A_RATE: begin
					if (pwdata_i[31:0] >= 32'(`TOS_RATE_MIN) && pwdata_i[31:0] <= 32'(`TOS_RATE_MAX)) begin
						rate_sel_a_rate_q <= pwdata_i[`TOS_RATE_W-1:0];
					end
				end
				`TOS_ADDR_PPS_WIDTH: pps_width_q <= pwdata_i[`TOS_RATE_W-1:0];
				default: ;
			endcase
		end
	end

	// second-mark pulse; a width of zero still gives one cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pps_cnt_q <= '0;
			pps_on_q <= 1'b0;
			minute_q <= 1'b0;
			even_q <= 1'b0;
		end else if (clk_en_i) begin
			if (epoch_i) begin
				pps_cnt_q <= pps_width_q;
				pps_on_q <= 1'b1;
				minute_q <= (time_i.second == 8'h00);
				even_q <= ~time_i.second[0];
			end else if (pps_cnt_q != '0) begin
				pps_cnt_q <= pps_cnt_q - `TOS_RATE_W'(1);
				pps_on_q <= (pps_cnt_q > `TOS_RATE_W'(1));
			end else begin
				pps_on_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prog_out_o <= 1'b0;
			fixed_out_o <= 1'b0;
			pps_p_o <= 1'b0;
			pps_n_o <= 1'b1;
			alarm_oe_o <= 1'b0;
			alarm_o <= 1'b0;
		end else if (clk_en_i) begin
			case (sel_q)
				SEL_RATE: prog_out_o <= prog_if.wave;
				SEL_TIMECODE: prog_out_o <= timecode_i;
				SEL_PER_MINUTE: prog_out_o <= pps_on_q & minute_q;
				SEL_EVEN_SECOND: prog_out_o <= pps_on_q & even_q;
				SEL_RISING: prog_out_o <= pps_on_q;
				SEL_FALLING: prog_out_o <= ~pps_on_q;
				SEL_RATE_SEL_A: prog_out_o <= rate_sel_a_if.wave;
				default: prog_out_o <= pps_on_q;
			endcase
			fixed_out_o <= `TOS_FIXED_IS_CODE ? timecode_i : fixed_if.wave;
			pps_p_o <= pps_on_q;
			pps_n_o <= ~pps_on_q;
			// open collector: the pin is only ever pulled low
			alarm_oe_o <= lock_lost_i | hw_fault_i;
			alarm_o <= 1'b0;
		end
	end

	function automatic logic [7:0] dig(input logic [3:0] n);
		return {4'h3, n};
	endfunction

	function automatic logic [7:0] hex(input logic [3:0] n);
		return (n < 4'hA) ? {4'h3, n} : 8'(`TOS_CH_A + {4'h0, n} - 8'h0A);
	endfunction

	always_comb begin
		ch = `TOS_CH_SP;
		msg_len = 6'd16;
		case (fmt_q)
			FMT_DOY_UTC, FMT_DOY_MODE: begin
				msg_len = 6'd16;
				// carriage return is the on-time byte, so the line closes at the mark
				case (idx_q)
					6'd0: ch = `TOS_CH_CR;
					6'd1: ch = `TOS_CH_LF;
					6'd2: ch = `TOS_CH_SOH;
					6'd3: ch = dig(snap_q.doy[11:8]);
					6'd4: ch = dig(snap_q.doy[7:4]);
					6'd5: ch = dig(snap_q.doy[3:0]);
					6'd6, 6'd9, 6'd12: ch = `TOS_CH_COLON;
					6'd7: ch = dig(snap_q.hour[7:4]);
					6'd8: ch = dig(snap_q.hour[3:0]);
					6'd10: ch = dig(snap_q.minute[7:4]);
					6'd11: ch = dig(snap_q.minute[3:0]);
					6'd13: ch = dig(snap_q.second[7:4]);
					6'd14: ch = dig(snap_q.second[3:0]);
					6'd15: ch = snap_q.locked ? `TOS_CH_SP : `TOS_CH_QM;
					default: ch = `TOS_CH_SP;
				endcase
			end
			FMT_YEAR, FMT_YEAR_LEAP: begin
				msg_len = (fmt_q == FMT_YEAR_LEAP) ? 6'd33 : 6'd27;
				case (idx_q)
					6'd0: ch = dig(snap_q.quality);
					6'd2: ch = dig(snap_q.year[15:12]);
					6'd3: ch = dig(snap_q.year[11:8]);
					6'd4: ch = dig(snap_q.year[7:4]);
					6'd5: ch = dig(snap_q.year[3:0]);
					6'd7: ch = dig(snap_q.doy[11:8]);
					6'd8: ch = dig(snap_q.doy[7:4]);
					6'd9: ch = dig(snap_q.doy[3:0]);
					6'd11: ch = dig(snap_q.hour[7:4]);
					6'd12: ch = dig(snap_q.hour[3:0]);
					6'd13, 6'd16: ch = `TOS_CH_COLON;
					6'd14: ch = dig(snap_q.minute[7:4]);
					6'd15: ch = dig(snap_q.minute[3:0]);
					6'd17: ch = dig(snap_q.second[7:4]);
					6'd18: ch = dig(snap_q.second[3:0]);
					6'd20: ch = snap_q.offset_neg ? `TOS_CH_MINUS : `TOS_CH_PLUS;
					6'd21: ch = dig(snap_q.offset[7:4]);
					6'd22: ch = dig(snap_q.offset[3:0]);
					6'd24: ch = (snap_q.mode == 2'h0) ? `TOS_CH_G :
						(snap_q.mode == 2'h1) ? `TOS_CH_L : `TOS_CH_U;
					6'd25: ch = (fmt_q == FMT_YEAR) ? `TOS_CH_CR : `TOS_CH_SP;
					6'd26: ch = (fmt_q == FMT_YEAR) ? `TOS_CH_LF : dig(snap_q.leap_now[7:4]);
					6'd27: ch = dig(snap_q.leap_now[3:0]);
					6'd29: ch = dig(snap_q.leap_next[7:4]);
					6'd30: ch = dig(snap_q.leap_next[3:0]);
					6'd31: ch = `TOS_CH_CR;
					6'd32: ch = `TOS_CH_LF;
					default: ch = `TOS_CH_SP;
				endcase
			end
			FMT_NENA: begin
				msg_len = 6'd19;
				case (idx_q)
					6'd0: ch = dig(snap_q.year[15:12]);
					6'd1: ch = dig(snap_q.year[11:8]);
					6'd2: ch = dig(snap_q.year[7:4]);
					6'd3: ch = dig(snap_q.year[3:0]);
					6'd5: ch = dig(snap_q.doy[11:8]);
					6'd6: ch = dig(snap_q.doy[7:4]);
					6'd7: ch = dig(snap_q.doy[3:0]);
					6'd9: ch = dig(snap_q.hour[7:4]);
					6'd10: ch = dig(snap_q.hour[3:0]);
					6'd12: ch = dig(snap_q.minute[7:4]);
					6'd13: ch = dig(snap_q.minute[3:0]);
					6'd15: ch = dig(snap_q.second[7:4]);
					6'd16: ch = dig(snap_q.second[3:0]);
					6'd17: ch = `TOS_CH_CR;
					6'd18: ch = `TOS_CH_LF;
					default: ch = `TOS_CH_COLON;
				endcase
			end
			default: begin
				msg_len = 6'd21;
				case (idx_q)
					6'd0: ch = `TOS_CH_DOLLAR;
					6'd1: ch = `TOS_CH_G;
					6'd2: ch = `TOS_CH_P;
					6'd3: ch = `TOS_CH_Z;
					6'd4: ch = `TOS_CH_D;
					6'd5: ch = `TOS_CH_A;
					6'd6: ch = `TOS_CH_COMMA;
					6'd7: ch = dig(snap_q.hour[7:4]);
					6'd8: ch = dig(snap_q.hour[3:0]);
					6'd9: ch = dig(snap_q.minute[7:4]);
					6'd10: ch = dig(snap_q.minute[3:0]);
					6'd11: ch = dig(snap_q.second[7:4]);
					6'd12: ch = dig(snap_q.second[3:0]);
					6'd13: ch = `TOS_CH_DOT;
					6'd14, 6'd15: ch = `TOS_CH_ZERO;
					6'd16: ch = `TOS_CH_STAR;
					6'd17: ch = hex(csum_q[7:4]);
					6'd18: ch = hex(csum_q[3:0]);
					6'd19: ch = `TOS_CH_CR;
					default: ch = `TOS_CH_LF;
				endcase
			end
		endcase
	end

	always_comb begin
		case (baud_q)
			BAUD_57600: div = `TOS_BAUD_DIV_W'(`TOS_DIV_57600);
			BAUD_19200: div = `TOS_BAUD_DIV_W'(`TOS_DIV_19200);
			BAUD_9600: div = `TOS_BAUD_DIV_W'(`TOS_DIV_9600);
			default: div = `TOS_BAUD_DIV_W'(BAUD_DIV_4800);
		endcase
	end

	// an epoch restarts the message even mid-frame so the on-time byte is never late
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= TX_IDLE;
			snap_q <= '0;
			idx_q <= 6'd0;
			csum_q <= 8'h00;
			sh_q <= 8'h00;
			bit_q <= 3'd0;
			par_acc_q <= 1'b0;
			baud_cnt_q <= '0;
			ser_tx_o <= 1'b1;
		end else if (clk_en_i) begin
			if (epoch_i) begin
				snap_q <= time_i;
				idx_q <= 6'd0;
				st_q <= TX_LOAD;
				ser_tx_o <= 1'b1;
			end else begin
				case (st_q)
					TX_IDLE: ser_tx_o <= 1'b1;
					TX_LOAD: begin
						sh_q <= ch;
						par_acc_q <= (par_q == PAR_ODD);
						if (idx_q == 6'd0) begin
							csum_q <= 8'h00;
						end else if (idx_q <= 6'd15) begin
							csum_q <= csum_q ^ ch;
						end
						ser_tx_o <= 1'b0;
						baud_cnt_q <= div - `TOS_BAUD_DIV_W'(1);
						st_q <= TX_START;
					end
					default: begin
						if (baud_cnt_q != '0) begin
							baud_cnt_q <= baud_cnt_q - `TOS_BAUD_DIV_W'(1);
						end else begin
							baud_cnt_q <= div - `TOS_BAUD_DIV_W'(1);
							case (st_q)
								TX_START: begin
									ser_tx_o <= sh_q[0];
									par_acc_q <= par_acc_q ^ sh_q[0];
									sh_q <= {1'b0, sh_q[7:1]};
									bit_q <= 3'd0;
									st_q <= TX_DATA;
								end
								TX_DATA: begin
									if (bit_q == 3'd7) begin
										ser_tx_o <= (par_q == PAR_NONE) ? 1'b1 : par_acc_q;
										st_q <= (par_q == PAR_NONE) ? TX_STOP : TX_PARITY;
									end else begin
										ser_tx_o <= sh_q[0];
										par_acc_q <= par_acc_q ^ sh_q[0];
										sh_q <= {1'b0, sh_q[7:1]};
										bit_q <= bit_q + 3'd1;
									end
								end
								TX_PARITY: begin
									ser_tx_o <= 1'b1;
									st_q <= TX_STOP;
								end
								TX_STOP: begin
									idx_q <= idx_q + 6'd1;
									st_q <= (idx_q + 6'd1 == msg_len) ? TX_IDLE : TX_LOAD;
								end
								default: st_q <= TX_IDLE;
							endcase
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### tos_timing_out_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tos_timing_out_assertions #(
	parameter int PPS_WIDTH_DEF = 20,
	parameter int BAUD_DIV_4800 = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic epoch_i,
	input wire logic lock_lost_i,
	input wire logic hw_fault_i,
	input wire logic fixed_out_o,
	input wire logic pps_p_o,
	input wire logic pps_n_o,
	input wire logic alarm_o,
	input wire logic alarm_oe_o,
	input wire logic ser_tx_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_pps_pair;
		pps_n_o == !pps_p_o;
	endproperty
	a_pps_pair: assert property (p_pps_pair) else $error("pps pair mismatch");
	property p_pps_epoch;
		$rose(pps_p_o) |-> $past(epoch_i, 2);
	endproperty
	a_pps_epoch: assert property (p_pps_epoch) else $error("pps edge off epoch");
	property p_pps_follow;
		epoch_i |-> ##2 pps_p_o;
	endproperty
	a_pps_follow: assert property (p_pps_follow) else $error("pps missing");
	property p_alarm_set;
		lock_lost_i || hw_fault_i |=> alarm_oe_o;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not raised");
	property p_alarm_clr;
		!(lock_lost_i || hw_fault_i) |=> !alarm_oe_o;
	endproperty
	a_alarm_clr: assert property (p_alarm_clr) else $error("alarm stuck");
	property p_alarm_data;
		!alarm_o;
	endproperty
	a_alarm_data: assert property (p_alarm_data) else $error("alarm data high");
	property p_tx_start;
		epoch_i |-> ##2 !ser_tx_o;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit late");
	property p_ready_wait;
		psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready timing");
	// a 10 MPPS square wave from 25 MHz never rests longer than two cycles
	property p_fixed_rate;
		$fell(fixed_out_o) |-> ##[1:2] fixed_out_o;
	endproperty
	a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate stalled");
endmodule
bind tos_timing_out tos_timing_out_assertions #(.PPS_WIDTH_DEF(PPS_WIDTH_DEF),
	.BAUD_DIV_4800(BAUD_DIV_4800)) i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .epoch_i(epoch_i),
	.lock_lost_i(lock_lost_i), .hw_fault_i(hw_fault_i), .fixed_out_o(fixed_out_o),
	.pps_p_o(pps_p_o), .pps_n_o(pps_n_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o),
	.ser_tx_o(ser_tx_o));
`default_nettype wire

// ### tos_timing_out_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_defs.svh"
module tos_timing_out_tb;
	import tos_pkg::*;
	localparam int DIV = 16;
	logic clk, rst = 1'b1, en = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, epoch = 1'b0;
	logic tc = 1'b0, ll = 1'b0, hf = 1'b0, m_en = 1'b0, err, stb, perr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, prog, fixd, pp, pn, al, aloe, tx;
	logic [7:0] rb;
	logic [1:0] par = 2'b00;
	tos_time_type tm = {16'h2025, 12'h123, 8'h04, 8'h56, 8'h07, 9'h0, 6'h0, 1'b1, 16'h0};
	int n_fail = 0, checks = 0, hi, rises;
	logic [7:0] q[$];
	wire alarm_line;
	// open-collector pin with an external pull-up
	assign alarm_line = aloe ? al : 1'b1;
	tos_timing_out #(.PPS_WIDTH_DEF(20), .BAUD_DIV_4800(DIV)) i_dut (.sys_clk_i(clk),
		.rst_i(rst), .clk_en_i(en), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .epoch_i(epoch), .time_i(tm), .timecode_i(tc),
		.lock_lost_i(ll), .hw_fault_i(hf), .prog_out_o(prog), .fixed_out_o(fixd),
		.pps_p_o(pp), .pps_n_o(pn), .alarm_o(al), .alarm_oe_o(aloe), .ser_tx_o(tx));
	tos_uart_model i_rx (.clk_i(clk), .en_i(m_en), .line_i(tx), .div_i(16'(DIV)),
		.par_i(par), .data_o(rb), .stb_o(stb), .err_o(perr));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (stb === 1'b1) begin
			q.push_back(rb);
			chk("rx frame", 32'h0, {31'h0, perr});
		end
	end
	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, e, g);
		end
	endtask
	task automatic clkn(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		clkn(4);
		rst <= 1'b0;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		// pready is judged at the rising edge itself, the request is released only after it
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			summarize();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic pulse();
		@(posedge clk);
		epoch <= 1'b1;
		@(posedge clk);
		epoch <= 1'b0;
	endtask
	task automatic meas(input int w, input int n);
		logic s, p;
		hi = 0;
		rises = 0;
		p = 1'b1;
		repeat (n) begin
			@(negedge clk);
			s = (w == 0) ? prog : (w == 1) ? fixd : pp;
			hi += int'(s === 1'b1);
			rises += int'(s === 1'b1 && p === 1'b0);
			p = s;
		end
	endtask
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (q.size() < n && k < 9000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 9000) begin
			chk("rx count", n, q.size());
			summarize();
		end
	endtask
	task automatic t_boot();
		int n;
		pulse();
		clkn(1);
		@(negedge clk);
		chk("start bit", 32'h0, {31'h0, tx});
		n = 0;
		while (tx === 1'b0 && n < 3000) begin
			n++;
			@(negedge clk);
		end
		chk("bit 9600", `TOS_CLK_HZ / 9600, n);
	endtask
	task automatic t_regs();
		rdc("ctrl", 12'h000, 32'h2004);
		rdc("width", 12'h00C, 32'h14);
		rdc("status", 12'h010, 32'h1);
		rdc("unmapped", 12'h020, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		wr(12'h000, 32'h2007);
		rdc("sel 7", 12'h000, 32'h2004);
		chk("pps_n", 32'h1, {31'h0, pn});
	endtask
	task automatic t_pps();
		pulse();
		meas(2, 40);
		chk("pps width", 20, hi);
		pulse();
		meas(0, 40);
		chk("rising", 20, hi);
		wr(12'h00C, 32'h5);
		wr(12'h000, 32'h5);
		pulse();
		meas(0, 40);
		chk("falling", 35, hi);
		pulse();
		meas(2, 40);
		chk("pps new width", 5, hi);
	endtask
	task automatic t_sel();
		for (int i = 0; i < 4; i++) begin
			wr(12'h000, 32'(2 + i / 2));
			tm.second <= 8'(2 * (i / 2) + i % 2);
			pulse();
			meas(0, 40);
			chk("minute or even", (i % 2) ? 0 : 5, hi);
		end
	endtask
	task automatic t_rates();
		wr(12'h004, 32'h1312D0);
		wr(12'h004, 32'h0);
		rdc("rate", 12'h004, 32'h1312D0);
		wr(12'h000, 32'h0);
		pulse();
		meas(0, 200);
		chk("prog rate", 1, rises >= 9 && rises <= 11);
		wr(12'h008, 32'h2625A0);
		wr(12'h000, 32'h6);
		meas(0, 200);
		chk("rate_sel_a rate", 1, rises >= 19 && rises <= 21);
		meas(1, 250);
		chk("fixed rate", 1, rises >= 99 && rises <= 101);
		wr(12'h000, 32'h1);
		tc <= 1'b1;
		clkn(4);
		@(negedge clk);
		chk("code high", 32'h1, {31'h0, prog});
		@(posedge clk);
		tc <= 1'b0;
		clkn(4);
		@(negedge clk);
		chk("code low", 32'h0, {31'h0, prog});
	endtask
	task automatic t_alarm();
		@(posedge clk);
		ll <= 1'b1;
		clkn(2);
		@(negedge clk);
		chk("alarm lock", 32'h0, {31'h0, alarm_line});
		@(posedge clk);
		ll <= 1'b0;
		hf <= 1'b1;
		clkn(2);
		@(negedge clk);
		chk("alarm fault", 32'h0, {31'h0, alarm_line});
		@(posedge clk);
		hf <= 1'b0;
		clkn(2);
		@(negedge clk);
		chk("alarm off", 32'h1, {31'h0, alarm_line});
	endtask
	task automatic t_doy(input logic lk, input logic [1:0] pm);
		logic [7:0] e [16];
		e = '{8'h0D, 8'h0A, 8'h01, 8'h31, 8'h32, 8'h33, 8'h3A, 8'h30, 8'h34, 8'h3A,
			8'h35, 8'h36, 8'h3A, 8'h30, 8'h37, lk ? 8'h20 : 8'h3F};
		par <= pm;
		wr(12'h000, {14'h0, pm, 16'h3004});
		tm.second <= 8'h07;
		tm.locked <= lk;
		q.delete();
		pulse();
		// listen only from the epoch on: the line was forced idle there, so no cut frame is seen
		m_en <= 1'b1;
		wait_rx(16);
		for (int i = 0; i < 16; i++)
			chk("doy byte", e[i], q[i]);
		clkn(200);
	endtask
	task automatic t_fmts();
		int f;
		int len;
		par <= 2'b00;
		for (int i = 0; i < 8; i++) begin
			f = (i < 6) ? i : 2;
			tm.mode <= 2'(i % 3);
			wr(12'h000, {16'h0, 4'h3, 1'b0, f[2:0], 8'h04});
			q.delete();
			pulse();
			wait_rx((f == 2 || f == 3) ? 25 : 16);
			// let the longest message drain before the next epoch restarts it
			clkn(1600);
			len = (f < 2) ? 16 : (f == 2) ? 27 : (f == 3) ? 33 : (f == 4) ? 19 : 21;
			chk("msg length", len, q.size());
			if (f == 2 || f == 3)
				chk("mode char", (i % 3 == 0) ? 8'h47 : (i % 3 == 1) ? 8'h4C : 8'h55, q[24]);
		end
	endtask
	initial begin
		do_reset();
		t_boot();
		do_reset();
		t_regs();
		t_pps();
		t_sel();
		t_rates();
		t_alarm();
		t_doy(1'b1, 2'b01);
		t_doy(1'b0, 2'b10);
		t_fmts();
		summarize();
	end
endmodule
`default_nettype wire

// ### tos_uart_model.sv
`timescale 1ns/1ns
`default_nettype none
module tos_uart_model (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic line_i,
	input wire logic [15:0] div_i,
	input wire logic [1:0] par_i,
	output logic [7:0] data_o,
	output logic stb_o,
	output logic err_o
);
	logic [7:0] b;
	logic bad;
	// mid-bit sampling with no resync inside a frame, like a plain pc uart
	initial begin
		stb_o = 1'b0;
		err_o = 1'b0;
		data_o = 8'h00;
		forever begin
			@(posedge clk_i);
			stb_o <= 1'b0;
			if (en_i && line_i === 1'b0) begin
				repeat (div_i / 2) @(posedge clk_i);
				bad = (line_i !== 1'b0);
				for (int k = 0; k < 8; k++) begin
					repeat (div_i) @(posedge clk_i);
					b[k] = line_i;
				end
				if (par_i != 2'b00) begin
					repeat (div_i) @(posedge clk_i);
					bad = bad | (line_i !== ((^b) ^ (par_i == 2'b01)));
				end
				repeat (div_i) @(posedge clk_i);
				bad = bad | (line_i !== 1'b1);
				data_o <= b;
				err_o <= bad;
				stb_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
